//--- core/spi_command_diag_frame.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_diag_regs.svh"

module spi_command_diag_frame #(
    parameter int NUM_REGS = 8
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // serial link pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        si,
    output var  logic        so,
    output var  logic        so_oe,
    // device status
    input  wire logic        limp_home_input_n,
    input  wire logic        bypass_monitor_flag,
    input  wire logic [3:0]  channel_fault_flag,
    input  wire logic [5:0]  channel_on_state,
    // register contents and frame status
    output var  logic [4*NUM_REGS-1:0] reg_data,
    output var  logic        reg_write_pulse,
    output var  logic        transfer_fault_flag
);
    import spi_diag_pkg::*;

    logic [2:0]  cs_sync_ff;
    logic [2:0]  sclk_sync_ff;
    logic [1:0]  si_sync_ff;
    logic [1:0]  lhi_sync_ff;
    logic        cs_fall;
    logic        cs_rise;
    logic        sclk_rise;
    logic        sclk_fall;
    frame_state_t state_ff;
    logic [7:0]  shift_ff;
    logic [`FRAME_CNT_W-1:0] bit_cnt_ff;
    logic        got_clk_ff;
    logic        frame_ok;
    resp_kind_t  resp_kind_ff;
    resp_kind_t  nxt_resp_kind;
    logic [2:0]  resp_idx_ff;
    logic [3:0]  regs_ff [NUM_REGS];
    logic [7:0]  diag_word;
    logic [7:0]  resp_word;
    logic        so_ff;
    logic        so_oe_ff;
    logic        ter_ff;
    logic        wr_pulse_ff;

    function automatic logic reg_implemented(input logic [2:0] idx);
        logic [7:0] mask;
        mask = `REG_IMPL_MASK;
        return mask[idx];
    endfunction

    // two-stage synchronisers; stage three only feeds edge detection
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_sync_ff   <= 3'h7;
            sclk_sync_ff <= 3'h0;
            si_sync_ff   <= 2'h0;
            lhi_sync_ff  <= 2'h3;
        end
        else
        begin
            cs_sync_ff   <= {cs_sync_ff[1:0], cs_n};
            sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
            si_sync_ff   <= {si_sync_ff[0], si};
            lhi_sync_ff  <= {lhi_sync_ff[0], limp_home_input_n};
        end
    end

    assign cs_fall   = cs_sync_ff[2] & ~cs_sync_ff[1];
    assign cs_rise   = ~cs_sync_ff[2] & cs_sync_ff[1];
    assign sclk_rise = ~sclk_sync_ff[2] & sclk_sync_ff[1]
                       & (state_ff == FR_ACTIVE);
    assign sclk_fall = sclk_sync_ff[2] & ~sclk_sync_ff[1]
                       & (state_ff == FR_ACTIVE);

    // length check: at least one clock and a whole number of bytes
    assign frame_ok = got_clk_ff && (bit_cnt_ff == '0);

    // limp-home pin low reads as one; only four internal fault flags
    always_comb
    begin
        diag_word    = 8'h00;
        diag_word[6] = ~lhi_sync_ff[1];
        diag_word[5] = bypass_monitor_flag;
        diag_word[3:0] = channel_fault_flag;
    end

    always_comb
    begin
        resp_word = diag_word;
        unique case (resp_kind_ff)
            RESP_DIAG: resp_word = diag_word;
            RESP_CHAN: resp_word = {`RESP_HDR_CHAN, channel_on_state};
            RESP_REG:  resp_word = {`RESP_HDR_REG, resp_idx_ff[1:0],
                                    regs_ff[resp_idx_ff]};
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            state_ff <= FR_IDLE;
        else if (cs_fall)
            state_ff <= FR_ACTIVE;
        else if (cs_rise)
            state_ff <= FR_IDLE;
    end

    // one shifter: answer leaves at the top, command enters at the bottom
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            shift_ff <= 8'h00;
        else if (cs_fall)
            shift_ff <= resp_word;
        else if (sclk_fall)
            shift_ff <= {shift_ff[6:0], si_sync_ff[1]};
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_ff <= '0;
            got_clk_ff <= 1'b0;
        end
        else if (cs_fall)
        begin
            bit_cnt_ff <= '0;
            got_clk_ff <= 1'b0;
        end
        else if (sclk_fall)
        begin
            bit_cnt_ff <= bit_cnt_ff + {{(`FRAME_CNT_W - 1){1'b0}}, 1'b1};
            got_clk_ff <= 1'b1;
        end
    end

    // serial output: flag first, then MSB first after each rising clock
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            so_ff    <= 1'b0;
            so_oe_ff <= 1'b0;
        end
        else if (cs_fall)
        begin
            so_ff    <= ter_ff;
            so_oe_ff <= 1'b1;
        end
        else if (cs_rise)
        begin
            so_ff    <= 1'b0;
            so_oe_ff <= 1'b0;
        end
        else if (sclk_rise)
            so_ff <= shift_ff[7];
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            ter_ff <= 1'b1;
        else if (cs_rise)
            ter_ff <= ~frame_ok;
    end

    // command decode at chip select rise
    always_comb
    begin
        nxt_resp_kind = RESP_DIAG;
        if (shift_ff[`CMD_WRITE_BIT])
            nxt_resp_kind = RESP_DIAG;
        else if (shift_ff[`CMD_DIAG_BIT])
            nxt_resp_kind = RESP_DIAG;
        else if (!reg_implemented(shift_ff[6:4]))
            nxt_resp_kind = RESP_DIAG;
        else if (shift_ff[6:4] == `REG_OUT_LOW_IDX
                 || shift_ff[6:4] == `REG_OUT_HIGH_IDX)
            nxt_resp_kind = RESP_CHAN;
        else
            nxt_resp_kind = RESP_REG;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            resp_kind_ff <= RESP_DIAG;
            resp_idx_ff  <= 3'h0;
        end
        else if (cs_rise)
        begin
            resp_kind_ff <= frame_ok ? nxt_resp_kind : RESP_DIAG;
            resp_idx_ff  <= shift_ff[6:4];
        end
    end

    // register writes; bank and address select, low nibble is data
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_ff[i] <= 4'(`REG_RESET_VALUES >> (4 * i));
            wr_pulse_ff <= 1'b0;
        end
        else
        begin
            wr_pulse_ff <= 1'b0;
            if (cs_rise && frame_ok && shift_ff[`CMD_WRITE_BIT]
                && reg_implemented(shift_ff[6:4]))
            begin
                regs_ff[shift_ff[6:4]] <= shift_ff[3:0];
                wr_pulse_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            reg_data <= '0;
        else
            for (int i = 0; i < NUM_REGS; i++)
                reg_data[4*i +: 4] <= regs_ff[i];
    end

    assign so                  = so_ff;
    assign so_oe               = so_oe_ff;
    assign reg_write_pulse     = wr_pulse_ff;
    assign transfer_fault_flag = ter_ff;

endmodule
`default_nettype wire

//--- core/spi_diag_pkg.sv
`default_nettype none
package spi_diag_pkg;

    typedef enum logic [1:0] {
        RESP_DIAG,
        RESP_CHAN,
        RESP_REG
    } resp_kind_t;

    typedef enum logic {
        FR_IDLE,
        FR_ACTIVE
    } frame_state_t;

endpackage
`default_nettype wire

//--- core/spi_diag_regs.svh
`ifndef SPI_DIAG_REGS_SVH
`define SPI_DIAG_REGS_SVH

// command frame fields
`define CMD_WRITE_BIT      7
`define CMD_BANK_BIT       6
`define CMD_ADDR_HI        5
`define CMD_ADDR_LO        4
`define CMD_DATA_HI        3
`define CMD_DIAG_BIT       0

// register index is {bank, addr}; index 4 is not implemented
`define REG_IMPL_MASK      8'hEF
`define REG_OUT_LOW_IDX    3'h0
`define REG_OUT_HIGH_IDX   3'h1

// low nibble reset values, index 7 down to 0
`define REG_RESET_VALUES   32'h7200_0800

// response form headers in bits 7:6
`define RESP_HDR_CHAN      2'h2
`define RESP_HDR_REG       2'h3

// frame length
`define FRAME_BITS         8
`define FRAME_CNT_W        3

`endif

//--- tb/spi_command_diag_frame_bench.sv
`timescale 1ns/1ps
`default_nettype none
module spi_command_diag_frame_bench;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    wire logic   cs_n, sclk, si, so, so_oe;
    // a released output reads as one, since so is cleared when so_oe drops
    wire logic   so_pin = so_oe ? so : ~so;
    logic        lhi_n = 1'b1;
    logic        byp = 1'b0;
    logic [3:0]  faults = 4'h0;
    logic [5:0]  chan = 6'h00;
    logic [31:0] reg_data;
    logic        pulse, tff, flag;
    logic [7:0]  rx;
    int          num_errors = 0;
    int          total_checks = 0;
    int          pulses = 0;
    int          p;
    always #25 clk_sys = ~clk_sys;
    always @(negedge clk_sys)
        if (pulse === 1'b1)
            pulses <= pulses + 1;
    spi_command_diag_frame u_dut (.clk_sys(clk_sys), .nrst(nrst),
        .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe),
        .limp_home_input_n(lhi_n), .bypass_monitor_flag(byp),
        .channel_fault_flag(faults), .channel_on_state(chan),
        .reg_data(reg_data), .reg_write_pulse(pulse),
        .transfer_fault_flag(tff));
    spi_diag_master u_master (.clk_sys(clk_sys), .cs_n(cs_n),
        .sclk(sclk), .si(si), .so(so_pin));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic fr(input logic [7:0] tx, input int n = 8);
        u_master.xfer(tx, n, rx, flag);
    endtask
    task automatic t_diag;
        lhi_n = 1'b0;
        byp = 1'b1;
        faults = 4'hA;
        fr(8'h01);
        check(flag, 1'b1);
        check(tff, 1'b0);
        check(so_oe, 1'b0);
        fr(8'h7F);
        check(flag, 1'b0);
        check(rx, 8'h6A);
        lhi_n = 1'b1;
        fr(8'h01);
        check(rx, 8'h2A);
    endtask
    task automatic t_write_read;
        byp = 1'b0;
        faults = 4'h5;
        chan = 6'h15;
        p = pulses;
        fr(8'h8F);
        check(reg_data[3:0], 4'hF);
        check(pulses, p + 1);
        fr(8'h20);
        check(rx, 8'h05);
        fr(8'h70);
        check(rx, 8'hE8);
        fr(8'h00);
        check(rx, 8'hF7);
        fr(8'h01);
        check(rx, 8'h95);
    endtask
    task automatic t_unimpl;
        p = pulses;
        fr(8'hC5);
        fr(8'hD9);
        check(rx, 8'h05);
        check(pulses, p + 1);
        check(reg_data, 32'h7290_080F);
        fr(8'h50);
        fr(8'h40);
        check(rx, 8'hD9);
        fr(8'h01);
        check(rx, 8'h05);
    endtask
    task automatic t_bad_frame;
        p = pulses;
        fr(8'hA3, 5);
        check(reg_data, 32'h7290_080F);
        check(pulses, p);
        check(tff, 1'b1);
        fr(8'h01);
        check(flag, 1'b1);
        check(rx, 8'h05);
        fr(8'h01, 16);
        check(flag, 1'b0);
        check(tff, 1'b0);
    endtask
    initial
    begin
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        check(reg_data, 32'h7200_0800);
        t_diag();
        t_write_read();
        t_unimpl();
        t_bad_frame();
        complete_run();
    end
    initial
    begin
        #500us;
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire

//--- tb/spi_diag_master.sv
`timescale 1ns/1ps
`default_nettype none
module spi_diag_master (
    input  wire logic clk_sys,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic si,
    input  wire logic so
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // n clocks; flag is the bit shown before the first rising clock
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx, output logic flag);
        cs_n = 1'b0;
        tick(8);
        flag = so;
        for (int i = 0; i < n; i++)
        begin
            if (i > 0)
                rx = {rx[6:0], so};
            sclk = 1'b1;
            si = tx[7 - i % 8];
            tick(4);
            sclk = 1'b0;
            tick(4);
        end
        rx = {rx[6:0], so};
        cs_n = 1'b1;
        si = 1'b0;
        tick(10);
    endtask
endmodule
`default_nettype wire

//--- tb/spi_diag_sva.sv
`timescale 1ns/1ps
`default_nettype none
module spi_diag_sva #(
    parameter int NUM_REGS = 8
) (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic                  cs_n,
    input wire logic                  sclk,
    input wire logic                  so,
    input wire logic                  so_oe,
    input wire logic [4*NUM_REGS-1:0] reg_data,
    input wire logic                  reg_write_pulse,
    input wire logic                  transfer_fault_flag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    oe_on_a: assert property
        ($fell(cs_n) |-> ##[1:6] so_oe)
        else $error("output not enabled after select");
    oe_off_a: assert property
        (cs_n [*8] |-> !so_oe)
        else $error("output driven while deselected");
    flag_out_a: assert property
        ($rose(so_oe) |-> so == transfer_fault_flag)
        else $error("leading bit differs from fault flag");
    so_shift_a: assert property
        (so_oe && $past(so_oe) && $changed(so) |-> $past(sclk, 2))
        else $error("output bit changed without rising clock");
    flag_hold_a: assert property
        ($changed(transfer_fault_flag) |-> cs_n)
        else $error("fault flag changed inside frame");
    reg_cause_a: assert property
        ($changed(reg_data) && $past(nrst, 2)
         |-> $past(reg_write_pulse) || reg_write_pulse)
        else $error("register changed without write");
    pulse_one_a: assert property
        (reg_write_pulse |=> !reg_write_pulse)
        else $error("write pulse longer than one cycle");
    pulse_idle_a: assert property
        (reg_write_pulse |-> cs_n)
        else $error("write taken while selected");
    cover property (reg_write_pulse);
    cover property ($rose(so_oe) && so);
    cover property ($rose(so_oe) && !so);
    cover property ($rose(transfer_fault_flag));
endmodule
bind spi_command_diag_frame spi_diag_sva #(.NUM_REGS(NUM_REGS)) u_sva (.*);
`default_nettype wire
